/* File: common/pmc_pkg.sv */
// pmc_pkg: shared constants and carriers for the loop mode and step controller
// assumes: single 100 MHz clock domain, register port with one-cycle read latency
package pmc_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_LOOPS     = 3;
    localparam int FREQ_W        = 32;
    localparam int HIST_DEPTH    = 8;
    localparam int HIST_IDX_W    = 3;
    localparam int ADDR_W        = 8;
    localparam int DATA_W        = 32;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STEP_WORD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STEP_CMD  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_HOLD_CFG  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_RAMP_CFG  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_XTAL_ADJ  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_FREQ0     = 8'h20;

    // ------------------------------------------------------------
    // field positions in OFS_CTRL (per loop byte: loop*8 + bit)
    // ------------------------------------------------------------
    localparam int CTRL_FAST_EN  = 0;
    localparam int CTRL_PPS      = 1;
    localparam int CTRL_RAMP_EN  = 2;
    localparam int CTRL_EXIT_BW  = 3;
    localparam int CTRL_PIN_SEL  = 4;
    localparam int CTRL_MASK     = 5;
    localparam int CTRL_LOOP_W   = 8;

    // step command bits in OFS_STEP_CMD
    localparam int CMD_UP        = 0;
    localparam int CMD_DOWN      = 1;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0]     CTRL_RST      = 32'h0000_0000;
    localparam logic [FREQ_W-1:0]     STEP_WORD_RST = 32'h0000_0001;
    localparam logic [HIST_IDX_W-1:0] WIN_RST       = 3'h3;
    localparam logic [HIST_IDX_W-1:0] DLY_RST       = 3'h1;
    localparam logic [5:0]            RAMP_SEL_RST  = 6'h00;
    localparam logic [15:0]           XTAL_ADJ_RST  = 16'h0000;
    // ramp selections span 0.2 ppm/s .. 40,000 ppm/s in about 40 steps
    localparam logic [5:0]            RAMP_SEL_MAX  = 6'h27;
    // crystal adjust limited to +/-1000 ppm, in 1 ppm units
    localparam logic signed [15:0]    XTAL_ADJ_LIM  = 16'sh03E8;
    // acquisition lengths in cycles: fast, normal, two-phase smart lock
    localparam logic [7:0]            ACQ_FAST_CYC  = 8'h08;
    localparam logic [7:0]            ACQ_NORM_CYC  = 8'h40;
    localparam logic [7:0]            ACQ_PH1_CYC   = 8'h10;
    localparam logic [7:0]            ACQ_PH2_CYC   = 8'h10;
    // history sample period in cycles
    localparam logic [7:0]            HIST_PER_CYC  = 8'h20;
    localparam logic [FREQ_W-1:0]     FREQ_NOMINAL  = 32'h8000_0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PMC_FREE   = 4'b0001,
        PMC_ACQ    = 4'b0010,
        PMC_LOCKED = 4'b0100,
        PMC_HOLD   = 4'b1000
    } pmc_mode_t;

    typedef struct packed {
        logic              fast_en;
        logic              pps;
        logic              ramp_en;
        logic              exit_bw;
        logic [HIST_IDX_W-1:0] win;
        logic [HIST_IDX_W-1:0] dly;
        logic [5:0]        ramp_sel;
        logic [FREQ_W-1:0] step_word;
    } pmc_loop_cfg_t;

    typedef struct packed {
        logic              up;
        logic              down;
    } pmc_step_req_t;

    typedef struct packed {
        pmc_mode_t         mode;
        logic              locked;
        logic              fast_bw;
        logic              smart_ph2;
        logic [FREQ_W-1:0] freq;
    } pmc_loop_stat_t;

endpackage

/* File: design/pmc_loop.sv */
// pmc_loop: mode machine, history averaging, ramp and step for one loop
// assumes: input validity already synchronised; step requests are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module pmc_loop (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic               init_done,
    input  wire logic               sel_valid,
    input  wire logic               any_valid,
    input  wire logic [31:0]        in_freq,
    input  wire pmc_pkg::pmc_loop_cfg_t cfg,
    input  wire pmc_pkg::pmc_step_req_t step,
    output pmc_pkg::pmc_loop_stat_t stat
);
    import pmc_pkg::*;

    typedef struct packed {
        pmc_mode_t                  mode;
        logic [7:0]                 cnt;
        logic [7:0]                 hcnt;
        logic                       ph2;
        logic                       ramping;
        logic [FREQ_W-1:0]          freq;
        logic [FREQ_W-1:0]          target;
        logic [HIST_IDX_W-1:0]      wr;
        logic [HIST_DEPTH*FREQ_W-1:0] hist;
        logic [FREQ_W-1:0]          hold_freq;
    } pmc_loop_state_t;

    pmc_loop_state_t st_reg;
    pmc_loop_state_t st_next;

    // average of win+1 samples, skipping dly newest
    function automatic logic [FREQ_W-1:0] hist_avg(
        input logic [HIST_DEPTH*FREQ_W-1:0] h,
        input logic [HIST_IDX_W-1:0]        wr,
        input logic [HIST_IDX_W-1:0]        win,
        input logic [HIST_IDX_W-1:0]        dly
    );
        logic [FREQ_W+HIST_IDX_W-1:0] sum;
        logic [HIST_IDX_W-1:0]        idx;
        sum = '0;
        for (int i = 0; i < HIST_DEPTH; i++) begin
            idx = wr - dly - HIST_IDX_W'(i) - 3'h1;
            if (HIST_IDX_W'(i) <= win) begin
                sum = sum + (FREQ_W+HIST_IDX_W)'(h[idx*FREQ_W +: FREQ_W]);
            end
        end
        // divide by the largest power of two not above win+1, cheap and monotonic
        return FREQ_W'(sum >> ((win >= 3'h7) ? 3 : (win >= 3'h3) ? 2 : (win >= 3'h1) ? 1 : 0));
    endfunction

    // ramp step per cycle doubles with selection up to 31, then wraps back from 32; loop bandwidth plays no part
    function automatic logic [FREQ_W-1:0] ramp_inc(input logic [5:0] sel);
        logic [5:0] s;
        s = (sel > RAMP_SEL_MAX) ? RAMP_SEL_MAX : sel;
        return FREQ_W'(32'h1) << s[4:0];
    endfunction

    always_comb begin
        logic [FREQ_W-1:0] inc;
        inc     = ramp_inc(cfg.ramp_sel);
        st_next = st_reg;
        case (st_reg.mode)
            PMC_FREE: begin
                st_next.freq = FREQ_NOMINAL;
                if (init_done && any_valid) begin
                    st_next.mode = PMC_ACQ;
                    st_next.cnt  = '0;
                    st_next.ph2  = 1'b0;
                end
            end
            PMC_ACQ: begin
                st_next.cnt = st_reg.cnt + 8'h01;
                // pull halfway toward input each cycle, glitch free
                st_next.freq = FREQ_W'(({1'b0, st_reg.freq} + {1'b0, in_freq}) >> 1);
                if (!any_valid) begin
                    st_next.mode = PMC_FREE;
                end else if (cfg.pps) begin
                    // coarse then fine phase
                    if (!st_reg.ph2 && st_reg.cnt >= ACQ_PH1_CYC) begin
                        st_next.ph2 = 1'b1;
                        st_next.cnt = '0;
                    end else if (st_reg.ph2 && st_reg.cnt >= ACQ_PH2_CYC) begin
                        st_next.mode = PMC_LOCKED;
                    end
                end else if (st_reg.cnt >= (cfg.fast_en ? ACQ_FAST_CYC : ACQ_NORM_CYC)) begin
                    st_next.mode = PMC_LOCKED;
                end
            end
            PMC_LOCKED: begin
                // record history while locked
                st_next.hcnt = st_reg.hcnt + 8'h01;
                if (st_reg.hcnt >= HIST_PER_CYC) begin
                    st_next.hcnt = '0;
                    st_next.hist[st_reg.wr*FREQ_W +: FREQ_W] = in_freq;
                    st_next.wr = st_reg.wr + 3'h1;
                end
                // stepping in locked mode; holdover steps only with pps
                if (step.up && !step.down) begin
                    st_next.freq = st_reg.freq + cfg.step_word;
                end else if (step.down && !step.up) begin
                    st_next.freq = st_reg.freq - cfg.step_word;
                end
                if (!sel_valid && !any_valid) begin
                    st_next.mode      = PMC_HOLD;
                    st_next.hold_freq = hist_avg(st_reg.hist, st_reg.wr, cfg.win, cfg.dly);
                    st_next.freq      = hist_avg(st_reg.hist, st_reg.wr, cfg.win, cfg.dly);
                end
            end
            PMC_HOLD: begin
                // 1 pps holdover allows steering otherwise steps ignored
                if (cfg.pps && step.up && !step.down) begin
                    st_next.freq = st_reg.freq + cfg.step_word;
                end else if (cfg.pps && step.down && !step.up) begin
                    st_next.freq = st_reg.freq - cfg.step_word;
                end
                if (any_valid && !st_reg.ramping) begin
                    if (cfg.ramp_en && !cfg.pps) begin
                        st_next.ramping = 1'b1; // measure gap first
                        st_next.target  = in_freq;
                    end else begin
                        // exit by loop bw or exit bw, both reacquire
                        st_next.mode = PMC_ACQ;
                        st_next.cnt  = cfg.exit_bw ? ACQ_NORM_CYC - ACQ_FAST_CYC : 8'h00;
                        st_next.ph2  = 1'b0;
                    end
                end else if (st_reg.ramping) begin
                    // linear ramp toward target
                    if (st_reg.freq < st_reg.target) begin
                        st_next.freq = (st_reg.target - st_reg.freq > inc) ?
                                       st_reg.freq + inc : st_reg.target;
                    end else if (st_reg.freq > st_reg.target) begin
                        st_next.freq = (st_reg.freq - st_reg.target > inc) ?
                                       st_reg.freq - inc : st_reg.target;
                    end else begin
                        st_next.ramping = 1'b0;
                        st_next.mode    = PMC_ACQ;
                        st_next.cnt     = ACQ_NORM_CYC;
                    end
                end
            end
            default: st_next.mode = PMC_FREE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg      <= '0;
            st_reg.mode <= PMC_FREE;
            st_reg.freq <= FREQ_NOMINAL;
        end else begin
            st_reg <= st_next;
        end
    end

    assign stat.mode      = st_reg.mode;
    assign stat.locked    = (st_reg.mode == PMC_LOCKED);
    assign stat.fast_bw   = (st_reg.mode == PMC_ACQ) && cfg.fast_en && !cfg.pps;
    assign stat.smart_ph2 = st_reg.ph2;
    assign stat.freq      = st_reg.freq;

endmodule
`default_nettype wire

/* File: design/pmc_step_sync.sv */
// pmc_step_sync: brings the step pins into the clock domain, one pulse per rising edge
// assumes: pins are asynchronous and held high for at least two clock periods
`timescale 1ns/100ps
`default_nettype none
module pmc_step_sync (
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    input  wire logic            step_up_pin,
    input  wire logic            step_down_pin,
    output pmc_pkg::pmc_step_req_t pulse
);
    import pmc_pkg::*;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
    } pmc_sync_state_t;

    pmc_sync_state_t st_reg;
    pmc_sync_state_t st_next;

    // ------------------------------------------------------------
    // two-flop sync then edge detect on the second stage
    // ------------------------------------------------------------
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = {step_up_pin, step_down_pin};
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // one pulse per rising edge
    assign pulse.up   = st_reg.s2[1] & ~st_reg.s3[1];
    assign pulse.down = st_reg.s2[0] & ~st_reg.s3[0];

endmodule
`default_nettype wire

/* File: design/pmc_top.sv */
// pmc_top: per-loop mode and step controller with register port
// assumes: register master on sys_clk; input validity and step pins asynchronous
`timescale 1ns/100ps
`default_nettype none
module pmc_top (
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    input  wire logic                       init_done,
    input  wire logic [2:0]                 sel_valid_in,
    input  wire logic [2:0]                 any_valid_in,
    input  wire logic [95:0]                in_freq,
    input  wire logic                       freq_step_up,
    input  wire logic                       freq_step_down,
    input  wire logic [pmc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [pmc_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [pmc_pkg::DATA_W-1:0] reg_rdata,
    output logic      [2:0]                 lock_lost_n,
    output logic      [15:0]                xtal_adj
);
    import pmc_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] ctrl;
        logic [FREQ_W-1:0] step_word;
        logic [HIST_IDX_W-1:0] win;
        logic [HIST_IDX_W-1:0] dly;
        logic [5:0]        ramp_sel;
        logic [15:0]       xtal;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        cmd;
        logic [5:0]        vsync1;
        logic [5:0]        vsync2;
        logic [2:0]        lol;
    } pmc_top_state_t;

    pmc_top_state_t st_reg;
    pmc_top_state_t st_next;

    pmc_step_req_t  pin_pulse;
    pmc_step_req_t  loop_step [NUM_LOOPS];
    pmc_loop_cfg_t  loop_cfg  [NUM_LOOPS];
    pmc_loop_stat_t loop_stat [NUM_LOOPS];

    function automatic logic ctrl_bit(input logic [DATA_W-1:0] c, input int loop, input int b);
        return c[loop*CTRL_LOOP_W + b];
    endfunction

    // clamp to +/-1000 ppm
    function automatic logic [15:0] xtal_clamp(input logic [15:0] v);
        logic signed [15:0] s;
        s = signed'(v);
        if (s > XTAL_ADJ_LIM) begin
            return XTAL_ADJ_LIM;
        end else if (s < -XTAL_ADJ_LIM) begin
            return -XTAL_ADJ_LIM;
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // step pin synchroniser
    // ------------------------------------------------------------
    pmc_step_sync u_sync (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .step_up_pin   (freq_step_up),
        .step_down_pin (freq_step_down),
        .pulse         (pin_pulse)
    );

    // ------------------------------------------------------------
    // loops
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_LOOPS; g++) begin : g_loop
            assign loop_cfg[g].fast_en   = ctrl_bit(st_reg.ctrl, g, CTRL_FAST_EN);
            assign loop_cfg[g].pps       = ctrl_bit(st_reg.ctrl, g, CTRL_PPS);
            assign loop_cfg[g].ramp_en   = ctrl_bit(st_reg.ctrl, g, CTRL_RAMP_EN);
            assign loop_cfg[g].exit_bw   = ctrl_bit(st_reg.ctrl, g, CTRL_EXIT_BW);
            assign loop_cfg[g].win       = st_reg.win;
            assign loop_cfg[g].dly       = st_reg.dly;
            assign loop_cfg[g].ramp_sel  = st_reg.ramp_sel;
            assign loop_cfg[g].step_word = st_reg.step_word;
            // pins reach only selected loops serial bits only masked loops
            assign loop_step[g].up   = (pin_pulse.up   & ctrl_bit(st_reg.ctrl, g, CTRL_PIN_SEL)) |
                                       (st_reg.cmd[CMD_UP]   & ctrl_bit(st_reg.ctrl, g, CTRL_MASK));
            assign loop_step[g].down = (pin_pulse.down & ctrl_bit(st_reg.ctrl, g, CTRL_PIN_SEL)) |
                                       (st_reg.cmd[CMD_DOWN] & ctrl_bit(st_reg.ctrl, g, CTRL_MASK));

            pmc_loop u_loop (
                .sys_clk   (sys_clk),
                .rst_n     (rst_n),
                .init_done (init_done),
                .sel_valid (st_reg.vsync2[g]),
                .any_valid (st_reg.vsync2[g+3]),
                .in_freq   (in_freq[g*32 +: 32]),
                .cfg       (loop_cfg[g]),
                .step      (loop_step[g]),
                .stat      (loop_stat[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // register port and sync
    // ------------------------------------------------------------
    always_comb begin
        st_next        = st_reg;
        st_next.vsync1 = {any_valid_in, sel_valid_in};
        st_next.vsync2 = st_reg.vsync1;
        st_next.cmd    = 2'b00;
        st_next.rdata  = '0;
        for (int i = 0; i < NUM_LOOPS; i++) begin
            st_next.lol[i] = ~loop_stat[i].locked;
        end
        if (reg_wr) begin
            case (reg_addr)
                OFS_CTRL:      st_next.ctrl      = reg_wdata;
                OFS_STEP_WORD: st_next.step_word = reg_wdata;
                OFS_STEP_CMD:  st_next.cmd       = reg_wdata[1:0]; // one-cycle pulse
                OFS_HOLD_CFG: begin
                    st_next.win = reg_wdata[2:0];
                    st_next.dly = reg_wdata[10:8];
                end
                OFS_RAMP_CFG:  st_next.ramp_sel  = (reg_wdata[5:0] > RAMP_SEL_MAX) ?
                                                    RAMP_SEL_MAX : reg_wdata[5:0];
                OFS_XTAL_ADJ:  st_next.xtal      = xtal_clamp(reg_wdata[15:0]);
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL:      st_next.rdata = st_reg.ctrl;
                OFS_STEP_WORD: st_next.rdata = st_reg.step_word;
                OFS_HOLD_CFG:  st_next.rdata = {21'h0, st_reg.dly, 5'h0, st_reg.win};
                OFS_RAMP_CFG:  st_next.rdata = {26'h0, st_reg.ramp_sel};
                OFS_XTAL_ADJ:  st_next.rdata = {16'h0, st_reg.xtal};
                OFS_STATUS: begin
                    for (int i = 0; i < NUM_LOOPS; i++) begin
                        st_next.rdata[i*8 +: 8] = {1'b0, loop_stat[i].smart_ph2,
                                                   loop_stat[i].fast_bw, loop_stat[i].locked,
                                                   loop_stat[i].mode};
                    end
                end
                OFS_FREQ0:         st_next.rdata = loop_stat[0].freq;
                OFS_FREQ0 + 8'h04: st_next.rdata = loop_stat[1].freq;
                OFS_FREQ0 + 8'h08: st_next.rdata = loop_stat[2].freq;
                default:           st_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg           <= '0;
            st_reg.ctrl      <= CTRL_RST;
            st_reg.step_word <= STEP_WORD_RST;
            st_reg.win       <= WIN_RST;
            st_reg.dly       <= DLY_RST;
            st_reg.ramp_sel  <= RAMP_SEL_RST;
            st_reg.xtal      <= XTAL_ADJ_RST;
            st_reg.lol       <= 3'h7;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata   = st_reg.rdata;
    assign lock_lost_n = st_reg.lol;
    assign xtal_adj    = st_reg.xtal;

endmodule
`default_nettype wire

/* File: test/pmc_chk.sv */
// pmc_chk: port assertions for pmc_top
// assumes: one clock, bound to pmc_top
`timescale 1ns/100ps
`default_nettype none
module pmc_chk
    import pmc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        init_done,
    input wire logic [2:0]  sel_valid_in,
    input wire logic [2:0]  any_valid_in,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [2:0]  lock_lost_n,
    input wire logic [15:0] xtal_adj
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_stat_rd;
        reg_rd && reg_addr == OFS_STATUS;
    endsequence
    // sync plus registering settles well inside 8 cycles
    sequence s_gone;
        (!any_valid_in[0] && !sel_valid_in[0]) [*8];
    endsequence
    a_xtal_range: assert property ($signed(xtal_adj) <= XTAL_ADJ_LIM
        && $signed(xtal_adj) >= -XTAL_ADJ_LIM) else $error("crystal adjust out of range");
    a_xtal_load: assert property (reg_wr && reg_addr == OFS_XTAL_ADJ
        && reg_wdata[15:0] == 16'h0005 |=> xtal_adj == 16'h0005) else $error("adjust not loaded");
    a_xtal_hold: assert property (!(reg_wr && reg_addr == OFS_XTAL_ADJ)
        |=> $stable(xtal_adj)) else $error("adjust moved without write");
    a_mode_onehot: assert property (s_stat_rd |=> $onehot(reg_rdata[3:0])
        && $onehot(reg_rdata[11:8])) else $error("mode not one-hot");
    a_ramp_clamp: assert property (reg_rd && reg_addr == OFS_RAMP_CFG
        |=> reg_rdata[5:0] <= RAMP_SEL_MAX) else $error("ramp select above top");
    a_lock_late: assert property ($fell(lock_lost_n[0])
        |-> $past(any_valid_in[0], 8)) else $error("lock without acquisition");
    a_hold_lost: assert property (s_gone |=> lock_lost_n[0]) else $error("lock kept");
    a_idle_free: assert property (!init_done |-> lock_lost_n == 3'h7) else $error("locked");
endmodule
bind pmc_top pmc_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .init_done(init_done),
    .sel_valid_in(sel_valid_in), .any_valid_in(any_valid_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lock_lost_n(lock_lost_n), .xtal_adj(xtal_adj));
`default_nettype wire

/* File: test/pmc_host.sv */
// pmc_host: servo-side driver of the step pins
// assumes: pins pass a two-flop synchroniser
`timescale 1ns/100ps
`default_nettype none
module pmc_host (
    input  wire logic sys_clk,
    output var  logic step_up,
    output var  logic step_down
);
    initial begin
        step_up = 1'b0;
        step_down = 1'b0;
    end
    // pins, not serial bits: quicker updates
    // one edge per step, low 3 cycles after
    task automatic pulse(input logic up, input int hold);
        @(posedge sys_clk);
        step_up <= up;
        step_down <= !up;
        repeat (hold) @(posedge sys_clk);
        step_up <= 1'b0;
        step_down <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

/* File: test/pmc_top_bench.sv */
// pmc_top_bench: mode and step scenarios
// assumes: pmc_host model, checker bound
`timescale 1ns/100ps
`default_nettype none
module pmc_top_bench;
    import pmc_pkg::*;
    logic sys_clk = 0, rst_n = 0, init_done = 0, reg_wr = 0, reg_rd = 0, up, dn;
    logic [2:0]  sel_v = '0, any_v = '0, lost_n;
    logic [95:0] in_freq = {3{32'h8000_1000}};
    logic [7:0]  reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, d, f, g;
    logic [15:0] xtal;
    int          num_errors = 0, check_count = 0;
    always #5 sys_clk = ~sys_clk;
    pmc_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .init_done(init_done),
        .sel_valid_in(sel_v), .any_valid_in(any_v), .in_freq(in_freq),
        .freq_step_up(up), .freq_step_down(dn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lock_lost_n(lost_n),
        .xtal_adj(xtal));
    pmc_host i_host (.sys_clk(sys_clk), .step_up(up), .step_down(dn));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic wait_lock;
        int n;
        n = 0;
        while (lost_n[0] !== 1'b0 && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        chk(32'(lost_n[0]), 32'h0);
    endtask
    task automatic t_regs;
        rd(OFS_STATUS, d);
        chk(d & 32'h00FF_FFFF, 32'h0001_0101);
        rd(OFS_STEP_WORD, d);
        chk(d, 32'h1);
        rd(8'hFC, d);
        chk(d, 32'h0);
        wr(OFS_XTAL_ADJ, 32'h7FFF);
        rd(OFS_XTAL_ADJ, d);
        chk(d, 32'h03E8);
        chk(32'(xtal), 32'h03E8);
        wr(OFS_XTAL_ADJ, 32'h8000);
        rd(OFS_RAMP_CFG, d);
        chk(32'(xtal), 32'hFC18);
        wr(OFS_XTAL_ADJ, 32'h5);
        wr(OFS_RAMP_CFG, 32'h3F);
        rd(OFS_RAMP_CFG, d);
        chk(d, 32'h27);
    endtask
    task automatic t_lock;
        wr(OFS_CTRL, 32'h0000_2031);
        wr(OFS_STEP_WORD, 32'h5);
        any_v <= 3'b001;
        sel_v <= 3'b001;
        repeat (3) @(posedge sys_clk);
        rd(OFS_STATUS, d);
        chk(32'(d[7:0]), 32'h22);
        wait_lock();
        rd(OFS_STATUS, d);
        chk(d & 32'h0000_FFFF, 32'h0114);
    endtask
    task automatic t_step;
        rd(OFS_FREQ0 + 8'h04, g);
        rd(OFS_FREQ0, f);
        i_host.pulse(1'b1, 6);
        rd(OFS_FREQ0, d);
        chk(d, f + 32'h5);
        i_host.pulse(1'b0, 2);
        rd(OFS_FREQ0, d);
        chk(d, f);
        wr(OFS_STEP_CMD, 32'h1);
        rd(OFS_FREQ0, d);
        chk(d, f + 32'h5);
        rd(OFS_FREQ0 + 8'h04, d);
        chk(d, g);
    endtask
    task automatic t_hold;
        // stay locked long enough to fill the history window
        repeat (170) @(posedge sys_clk);
        any_v <= 3'b000;
        sel_v <= 3'b000;
        repeat (12) @(negedge sys_clk);
        chk(32'(lost_n[0]), 32'h1);
        rd(OFS_STATUS, d);
        chk(32'(d[3:0]), 32'h8);
        rd(OFS_FREQ0, f);
        chk(f, 32'h8000_1000);
        i_host.pulse(1'b1, 2);
        rd(OFS_FREQ0, d);
        chk(d, f);
        any_v <= 3'b001;
        sel_v <= 3'b001;
        wait_lock();
    endtask
    task automatic t_ramp;
        wr(OFS_CTRL, 32'h0000_2235);
        any_v <= 3'b000;
        sel_v <= 3'b000;
        repeat (12) @(posedge sys_clk);
        in_freq[31:0] <= 32'h8000_1400;
        any_v <= 3'b011;
        sel_v <= 3'b011;
        wait_lock();
        rd(OFS_FREQ0, d);
        chk(d, 32'h8000_1400);
        repeat (8) @(posedge sys_clk);
        rd(OFS_STATUS, d);
        chk(32'(d[15:8]), 32'h42);
        repeat (14) @(posedge sys_clk);
        any_v <= 3'b001;
        sel_v <= 3'b001;
        repeat (6) @(posedge sys_clk);
        rd(OFS_FREQ0 + 8'h04, f);
        wr(OFS_STEP_CMD, 32'h1);
        rd(OFS_FREQ0 + 8'h04, d);
        chk(d, f + 32'h5);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        init_done <= 1'b1;
        t_regs();
        t_lock();
        t_step();
        t_hold();
        t_ramp();
        results();
    end
    // whole run is under 2000 cycles
    initial begin
        #100000;
        num_errors++;
        results();
    end
endmodule
`default_nettype wire
